// ### hdl/charge_target_decode.sv
module charge_target_decode
    import charger_cfg_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [6:0]  cv_code,
    input  wire logic [1:0]  cv_offset,
    input  wire logic        cool_voltage_drop,
    input  wire logic [1:0]  trickle_sel,
    input  wire logic [3:0]  ocp_code,
    input  wire logic [8:0]  fast_code,
    input  wire logic        cool_current_halve,
    output logic      [13:0] termination_mv,
    output logic      [9:0]  trickle_ma,
    output logic             ocp_enable,
    output logic      [13:0] ocp_ma,
    output logic      [8:0]  fast_code_applied
);
    logic [13:0] cv_mv;
    logic [13:0] offset_mv;
    logic [13:0] ocp_steps;

    always_comb begin
        cv_mv = CV_BASE_MV + 14'(cv_code) * CV_STEP_MV;
        case (cv_offset)
            2'h1:    offset_mv = CV_OFS1_MV;
            2'h2:    offset_mv = CV_OFS2_MV;
            2'h3:    offset_mv = CV_OFS3_MV;
            default: offset_mv = 14'h0000;
        endcase
        ocp_steps = 14'(ocp_code) - 14'd1;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            termination_mv    <= CV_BASE_MV;
            trickle_ma        <= TRICKLE_STEP_MA;
            ocp_enable        <= 1'b0;
            ocp_ma            <= 14'h0000;
            fast_code_applied <= 9'h000;
        end else begin
            // Two cells, so the per-cell drop is doubled
            termination_mv <= cool_voltage_drop
                ? cv_mv + offset_mv - COOL_DROP_MV
                : cv_mv + offset_mv;
            trickle_ma <= (10'(trickle_sel) + 10'd1) * TRICKLE_STEP_MA;
            ocp_enable <= (ocp_code != OCP_OFF_CODE);
            ocp_ma     <= (ocp_code == OCP_OFF_CODE) ? 14'h0000
                : OCP_BASE_MA + ocp_steps * OCP_STEP_MA;
            fast_code_applied <= cool_current_halve
                ? {1'b0, fast_code[8:1]} : fast_code;
        end
    end
endmodule

// ### hdl/charger_cfg_pkg.sv
package charger_cfg_pkg;

    // Register offsets on the device register port
    localparam logic [7:0] OFFSET_VOLTAGE_CFG   = 8'h1a;
    localparam logic [7:0] OFFSET_OFFSET_CFG    = 8'h1b;
    localparam logic [7:0] OFFSET_STROBE_LOCK   = 8'h1c;
    localparam logic [7:0] OFFSET_THERMAL_CFG   = 8'h1d;

    // Values after reset
    localparam logic [7:0] RESET_VOLTAGE_CFG    = 8'h00;
    localparam logic [7:0] RESET_OFFSET_CFG     = 8'h04;
    localparam logic [7:0] RESET_STROBE_LOCK    = 8'h00;
    localparam logic [7:0] RESET_THERMAL_CFG    = 8'h32;
    localparam logic [7:0] RESET_READ_DATA      = 8'h00;

    // Field positions
    localparam int TOP_BIT_POS        = 7;
    localparam int CV_CODE_LSB        = 0;
    localparam int CV_OFFSET_LSB      = 6;
    localparam int TRICKLE_LSB        = 4;
    localparam int OVERCURRENT_LSB    = 0;
    localparam int STROBE_POS         = 7;
    localparam int RESERVED_LSB       = 5;
    localparam int SPARE_POS          = 4;
    localparam int UNLOCK_LSB         = 2;
    localparam int WDOG_CLEAR_LSB     = 0;
    localparam int PROFILE_EN_POS     = 7;
    localparam int SETPOINT_LSB       = 3;
    localparam int COOL_VOLT_POS      = 2;
    localparam int COOL_CURR_POS      = 1;
    localparam int SHIP_POS           = 0;

    // Codes
    localparam logic [1:0] UNLOCK_CODE      = 2'h3;
    localparam logic [1:0] WDOG_CLEAR_CODE  = 2'h1;
    localparam logic [3:0] OCP_OFF_CODE     = 4'h0;
    localparam logic [3:0] SETPOINT_MAX     = 4'h9;

    // Analog scales, millivolts, milliamps and degrees
    localparam logic [13:0] CV_BASE_MV      = 14'd8100;
    localparam logic [13:0] CV_STEP_MV      = 14'd6;
    localparam logic [13:0] CV_OFS1_MV      = 14'd24;
    localparam logic [13:0] CV_OFS2_MV      = 14'd36;
    localparam logic [13:0] CV_OFS3_MV      = 14'd42;
    localparam logic [13:0] COOL_DROP_MV    = 14'd360;
    localparam logic [9:0]  TRICKLE_STEP_MA = 10'd125;
    localparam logic [13:0] OCP_BASE_MA     = 14'd3000;
    localparam logic [13:0] OCP_STEP_MA     = 14'd500;
    localparam logic [7:0]  REG_BASE_C      = 8'd85;
    localparam logic [7:0]  REG_STEP_C      = 8'd5;

endpackage

// ### hdl/charger_config_regs.sv
// Behaviour
// - Termination code maps linearly, 8.100 V plus 6 mV per step.
// - Reading the termination code returns the setting actually applied.
// - Bit 7 of the voltage register is the fast-current code top bit.
// - Two-bit offset adds 0, 24, 36 or 42 mV to termination.
// - Two-bit trickle select gives 125, 250, 375 or 500 mA.
// - Overcurrent code zero disables; 1..15 give 3.0 A to 10.0 A.
// - Load strobe copies top bit and low byte to active current.
// - Protected registers accept writes only while unlock field is 11.
// - Any other unlock field value locks the protected registers.
// - Watchdog restarts only on clear code 01 while watchdog enabled.
// - Temperature profile disabled means no thermistor-based adjustment.
// - Setpoint 85 to 130 C; above it, fold back and flag.
// - Cool zone with voltage bit lowers termination by 180 mV per cell.
// - Cool zone with current bit halves the fast-charge current.
// - Bit 0 of thermal register enables factory ship mode.
module charger_config_regs
    import charger_cfg_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    input  wire logic [7:0]  fast_current_low_byte,
    input  wire logic        watchdog_enable,
    input  wire logic        thermistor_cool_zone,
    input  wire logic [7:0]  junction_temp_c,
    output logic             protect_unlocked,
    output logic             watchdog_restart,
    output logic      [8:0]  active_fast_current_code,
    output logic      [8:0]  fast_current_target_code,
    output logic      [13:0] termination_mv,
    output logic      [9:0]  trickle_ma,
    output logic             overcurrent_enable,
    output logic      [13:0] overcurrent_ma,
    output logic      [7:0]  thermal_setpoint_c,
    output logic             thermal_regulation_flag,
    output logic             current_foldback,
    output logic             factory_ship_enable,
    output logic             spare_bit
);

    // Stored register fields
    logic       fast_current_top_bit_reg;
    logic [6:0] termination_voltage_code_reg;
    logic [6:0] applied_cv_code_reg;
    logic [1:0] termination_voltage_offset_reg;
    logic [1:0] trickle_current_select_reg;
    logic [3:0] overcurrent_threshold_reg;
    logic       fast_current_load_strobe_reg;
    logic [1:0] reserved_field_reg;
    logic       spare_bit_reg;
    logic [1:0] protect_unlock_field_reg;
    logic [1:0] watchdog_clear_field_reg;
    logic       temperature_profile_enable_reg;
    logic [3:0] thermal_regulation_setpoint_reg;
    logic       cool_zone_voltage_reduce_reg;
    logic       cool_zone_current_halve_reg;
    logic       factory_ship_enable_reg;
    logic [8:0] active_fast_current_reg;
    logic       watchdog_restart_reg;
    logic [7:0] reg_rdata_reg;
    logic       reg_rvalid_reg;

    // Thermistor zone arrives from the analog comparator, asynchronous
    logic       cool_zone_meta_reg;
    logic       cool_zone_sync_reg;

    // Write decode
    logic       hit_voltage;
    logic       hit_offset;
    logic       hit_strobe;
    logic       hit_thermal;
    logic       unlocked;
    logic       cool_adjust;
    logic       cool_voltage_drop;
    logic       cool_current_halve;
    logic [7:0] read_value;

    always_comb begin
        hit_voltage = reg_write && (reg_addr == OFFSET_VOLTAGE_CFG);
        hit_offset  = reg_write && (reg_addr == OFFSET_OFFSET_CFG);
        hit_strobe  = reg_write && (reg_addr == OFFSET_STROBE_LOCK);
        hit_thermal = reg_write && (reg_addr == OFFSET_THERMAL_CFG);
        unlocked    = (protect_unlock_field_reg == UNLOCK_CODE);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cool_zone_meta_reg <= 1'b0;
            cool_zone_sync_reg <= 1'b0;
        end else begin
            cool_zone_meta_reg <= thermistor_cool_zone;
            cool_zone_sync_reg <= cool_zone_meta_reg;
        end
    end

    // Voltage register; protected
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fast_current_top_bit_reg     <= RESET_VOLTAGE_CFG[TOP_BIT_POS];
            termination_voltage_code_reg <= RESET_VOLTAGE_CFG[CV_CODE_LSB+:7];
        end else if (hit_voltage && unlocked) begin
            fast_current_top_bit_reg     <= reg_wdata[TOP_BIT_POS];
            termination_voltage_code_reg <= reg_wdata[CV_CODE_LSB+:7];
        end
    end

    // The charger picks up a new code one cycle after the write lands;
    // reads follow the applied copy so software never sees a value early
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            applied_cv_code_reg <= RESET_VOLTAGE_CFG[CV_CODE_LSB+:7];
        end else begin
            applied_cv_code_reg <= termination_voltage_code_reg;
        end
    end

    // Offset, trickle and overcurrent register; protected
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            termination_voltage_offset_reg <= RESET_OFFSET_CFG[CV_OFFSET_LSB+:2];
            trickle_current_select_reg     <= RESET_OFFSET_CFG[TRICKLE_LSB+:2];
            overcurrent_threshold_reg <= RESET_OFFSET_CFG[OVERCURRENT_LSB+:4];
        end else if (hit_offset && unlocked) begin
            termination_voltage_offset_reg <= reg_wdata[CV_OFFSET_LSB+:2];
            trickle_current_select_reg     <= reg_wdata[TRICKLE_LSB+:2];
            overcurrent_threshold_reg      <= reg_wdata[OVERCURRENT_LSB+:4];
        end
    end

    // Control register; never locked, or the lock could not be opened
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reserved_field_reg       <= RESET_STROBE_LOCK[RESERVED_LSB+:2];
            spare_bit_reg            <= RESET_STROBE_LOCK[SPARE_POS];
            protect_unlock_field_reg <= RESET_STROBE_LOCK[UNLOCK_LSB+:2];
            watchdog_clear_field_reg <= RESET_STROBE_LOCK[WDOG_CLEAR_LSB+:2];
        end else if (hit_strobe) begin
            // Stored as written; keeping them zero is software's duty
            reserved_field_reg       <= reg_wdata[RESERVED_LSB+:2];
            spare_bit_reg            <= reg_wdata[SPARE_POS];
            protect_unlock_field_reg <= reg_wdata[UNLOCK_LSB+:2];
            watchdog_clear_field_reg <= reg_wdata[WDOG_CLEAR_LSB+:2];
        end
    end

    // Load strobe: a fresh write wins over the self-clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fast_current_load_strobe_reg <= RESET_STROBE_LOCK[STROBE_POS];
        end else if (hit_strobe && reg_wdata[STROBE_POS]) begin
            fast_current_load_strobe_reg <= 1'b1;
        end else begin
            fast_current_load_strobe_reg <= 1'b0;
        end
    end

    // Active current code changes only on the strobe, never on a plain write
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_fast_current_reg <= 9'h000;
        end else if (fast_current_load_strobe_reg) begin
            active_fast_current_reg <= {fast_current_top_bit_reg,
                                        fast_current_low_byte};
        end
    end

    // Watchdog restart pulse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            watchdog_restart_reg <= 1'b0;
        end else begin
            watchdog_restart_reg <= hit_strobe && watchdog_enable
                && (reg_wdata[WDOG_CLEAR_LSB+:2] == WDOG_CLEAR_CODE);
        end
    end

    // Thermal profile register; protected
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            temperature_profile_enable_reg  <= RESET_THERMAL_CFG[PROFILE_EN_POS];
            thermal_regulation_setpoint_reg <= RESET_THERMAL_CFG[SETPOINT_LSB+:4];
            cool_zone_voltage_reduce_reg    <= RESET_THERMAL_CFG[COOL_VOLT_POS];
            cool_zone_current_halve_reg     <= RESET_THERMAL_CFG[COOL_CURR_POS];
            factory_ship_enable_reg         <= RESET_THERMAL_CFG[SHIP_POS];
        end else if (hit_thermal && unlocked) begin
            temperature_profile_enable_reg  <= reg_wdata[PROFILE_EN_POS];
            thermal_regulation_setpoint_reg <= reg_wdata[SETPOINT_LSB+:4];
            cool_zone_voltage_reduce_reg    <= reg_wdata[COOL_VOLT_POS];
            cool_zone_current_halve_reg     <= reg_wdata[COOL_CURR_POS];
            factory_ship_enable_reg         <= reg_wdata[SHIP_POS];
        end
    end

    // Cool-zone adjustments apply only with the temperature profile on
    always_comb begin
        cool_adjust        = temperature_profile_enable_reg
                             && cool_zone_sync_reg;
        cool_voltage_drop  = cool_adjust && cool_zone_voltage_reduce_reg;
        cool_current_halve = cool_adjust && cool_zone_current_halve_reg;
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (reg_addr)
            OFFSET_VOLTAGE_CFG: begin
                read_value = {fast_current_top_bit_reg, applied_cv_code_reg};
            end
            OFFSET_OFFSET_CFG: begin
                read_value = {termination_voltage_offset_reg,
                              trickle_current_select_reg,
                              overcurrent_threshold_reg};
            end
            OFFSET_STROBE_LOCK: begin
                read_value = {fast_current_load_strobe_reg, reserved_field_reg,
                              spare_bit_reg, protect_unlock_field_reg,
                              watchdog_clear_field_reg};
            end
            OFFSET_THERMAL_CFG: begin
                read_value = {temperature_profile_enable_reg,
                              thermal_regulation_setpoint_reg,
                              cool_zone_voltage_reduce_reg,
                              cool_zone_current_halve_reg,
                              factory_ship_enable_reg};
            end
            default: begin
                read_value = RESET_READ_DATA;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata_reg  <= RESET_READ_DATA;
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rvalid_reg <= reg_read;
            if (reg_read) begin
                reg_rdata_reg <= read_value;
            end
        end
    end

    charge_target_decode u_decode (
        .clock              (clock),
        .rst_n              (rst_n),
        .cv_code            (applied_cv_code_reg),
        .cv_offset          (termination_voltage_offset_reg),
        .cool_voltage_drop  (cool_voltage_drop),
        .trickle_sel        (trickle_current_select_reg),
        .ocp_code           (overcurrent_threshold_reg),
        .fast_code          (active_fast_current_reg),
        .cool_current_halve (cool_current_halve),
        .termination_mv     (termination_mv),
        .trickle_ma         (trickle_ma),
        .ocp_enable         (overcurrent_enable),
        .ocp_ma             (overcurrent_ma),
        .fast_code_applied  (fast_current_target_code)
    );

    thermal_regulation u_thermal (
        .clock           (clock),
        .rst_n           (rst_n),
        .setpoint_code   (thermal_regulation_setpoint_reg),
        .junction_temp_c (junction_temp_c),
        .setpoint_c      (thermal_setpoint_c),
        .regulating      (thermal_regulation_flag)
    );

    always_comb begin
        reg_rdata                = reg_rdata_reg;
        reg_rvalid               = reg_rvalid_reg;
        protect_unlocked         = unlocked;
        watchdog_restart         = watchdog_restart_reg;
        active_fast_current_code = active_fast_current_reg;
        current_foldback         = thermal_regulation_flag;
        factory_ship_enable      = factory_ship_enable_reg;
        spare_bit                = spare_bit_reg;
    end

endmodule

// ### hdl/thermal_regulation.sv
module thermal_regulation
    import charger_cfg_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [3:0] setpoint_code,
    input  wire logic [7:0] junction_temp_c,
    output logic      [7:0] setpoint_c,
    output logic            regulating
);
    logic [3:0] code_clamped;
    logic [7:0] limit_c;

    always_comb begin
        // Undefined codes fall back to the hottest defined setpoint
        code_clamped = (setpoint_code > SETPOINT_MAX)
            ? SETPOINT_MAX : setpoint_code;
        limit_c = REG_BASE_C + 8'(code_clamped) * REG_STEP_C;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            setpoint_c <= REG_BASE_C;
            regulating <= 1'b0;
        end else begin
            setpoint_c <= limit_c;
            regulating <= (junction_temp_c > limit_c);
        end
    end
endmodule

// ### testbench/charger_config_regs_monitor.sv
module charger_config_regs_monitor
    import charger_cfg_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rvalid,
    input wire logic        watchdog_enable,
    input wire logic [7:0]  junction_temp_c,
    input wire logic        protect_unlocked,
    input wire logic        watchdog_restart,
    input wire logic [8:0]  active_fast_current_code,
    input wire logic [8:0]  fast_current_target_code,
    input wire logic [9:0]  trickle_ma,
    input wire logic        overcurrent_enable,
    input wire logic [13:0] overcurrent_ma,
    input wire logic [7:0]  thermal_setpoint_c,
    input wire logic        thermal_regulation_flag,
    input wire logic        current_foldback,
    input wire logic        factory_ship_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic ctl_wr;
    assign ctl_wr = reg_write && reg_addr == OFFSET_STROBE_LOCK;
    property p_read_answer;
        reg_rvalid == $past(reg_read);
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("late read answer");
    property p_unlock;
        ctl_wr && reg_wdata[3:2] == UNLOCK_CODE |=> protect_unlocked;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock code did not unlock");
    property p_lock;
        ctl_wr && reg_wdata[3:2] != UNLOCK_CODE |=> !protect_unlocked;
    endproperty
    a_lock: assert property (p_lock)
        else $error("other code did not lock");
    property p_kick;
        ctl_wr && reg_wdata[1:0] == WDOG_CLEAR_CODE && watchdog_enable
            |=> watchdog_restart;
    endproperty
    a_kick: assert property (p_kick)
        else $error("no watchdog restart");
    property p_kick_cause;
        watchdog_restart |-> $past(ctl_wr) && $past(watchdog_enable)
            && $past(reg_wdata[1:0]) == WDOG_CLEAR_CODE;
    endproperty
    a_kick_cause: assert property (p_kick_cause)
        else $error("stray watchdog restart");
    property p_strobe;
        $changed(active_fast_current_code) |-> $past(reg_write, 2)
            && $past(reg_addr, 2) == OFFSET_STROBE_LOCK
            && $past(reg_wdata[7], 2);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("stray current load");
    property p_ship;
        $changed(factory_ship_enable) |-> $past(reg_write)
            && $past(reg_addr) == OFFSET_THERMAL_CFG
            && $past(protect_unlocked);
    endproperty
    a_ship: assert property (p_ship)
        else $error("stray ship mode change");
    property p_trickle;
        trickle_ma % 125 == 0 && trickle_ma != 0 && trickle_ma <= 500;
    endproperty
    a_trickle: assert property (p_trickle)
        else $error("trickle current off grid");
    property p_ocp;
        overcurrent_enable ? (overcurrent_ma >= 3000 &&
            overcurrent_ma <= 10000 && overcurrent_ma % 500 == 0)
            : overcurrent_ma == 0;
    endproperty
    a_ocp: assert property (p_ocp)
        else $error("overcurrent threshold off grid");
    property p_setpoint;
        thermal_setpoint_c >= 85 && thermal_setpoint_c <= 130
            && thermal_setpoint_c % 5 == 0;
    endproperty
    a_setpoint: assert property (p_setpoint)
        else $error("setpoint outside 85 to 130");
    property p_flag;
        ($stable(junction_temp_c) && $stable(thermal_setpoint_c))[*3]
            |-> thermal_regulation_flag ==
            (junction_temp_c > thermal_setpoint_c)
            && current_foldback == thermal_regulation_flag;
    endproperty
    a_flag: assert property (p_flag)
        else $error("wrong regulation flag");
    property p_halve;
        $stable(active_fast_current_code)[*2] |->
            fast_current_target_code == active_fast_current_code ||
            fast_current_target_code == (active_fast_current_code >> 1);
    endproperty
    a_halve: assert property (p_halve)
        else $error("bad target current");
    c_read: cover property (reg_read ##1 reg_rvalid);
    c_strobe: cover property (ctl_wr && reg_wdata[7]);
    c_kick: cover property (watchdog_restart);
    c_flag: cover property (thermal_regulation_flag);
endmodule

bind charger_config_regs charger_config_regs_monitor mon_u (.*);

// ### testbench/host_port_model.sv
module host_port_model
    import charger_cfg_pkg::*;
(
    input  wire logic       clock,
    output logic            reg_write,
    output logic            reg_read,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = (a == OFFSET_STROBE_LOCK) ? (d & 8'h9f) : d;
        @(negedge clock);
        reg_write = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(negedge clock);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_read = 1'b0;
        reg_addr = ~reg_addr;
        d = reg_rdata;
        v = reg_rvalid;
    endtask
    task automatic unlock();
        wr(OFFSET_STROBE_LOCK, 8'h0c);
    endtask
endmodule

// ### testbench/test_charger_config_regs.sv
module test_charger_config_regs
    import charger_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst_n, reg_write, reg_read, reg_rvalid;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, fast_current_low_byte;
    logic        watchdog_enable, thermistor_cool_zone, protect_unlocked;
    logic [7:0]  junction_temp_c, thermal_setpoint_c;
    logic        watchdog_restart, overcurrent_enable, spare_bit;
    logic [8:0]  active_fast_current_code, fast_current_target_code;
    logic [13:0] termination_mv, overcurrent_ma;
    logic [9:0]  trickle_ma;
    logic        thermal_regulation_flag, current_foldback;
    logic        factory_ship_enable;
    int          errors = 0;
    int          n_checks = 0;
    int          ofs [4] = '{0, 24, 36, 42};
    int          e;
    charger_config_regs dut_u (.clock, .rst_n, .reg_write, .reg_read,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .fast_current_low_byte, .watchdog_enable, .thermistor_cool_zone,
        .junction_temp_c, .protect_unlocked, .watchdog_restart,
        .active_fast_current_code, .fast_current_target_code,
        .termination_mv, .trickle_ma, .overcurrent_enable, .overcurrent_ma,
        .thermal_setpoint_c, .thermal_regulation_flag, .current_foldback,
        .factory_ship_enable, .spare_bit);
    host_port_model host_u (.clock, .reg_write, .reg_read, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rvalid);
    always #2 clock = ~clock;
    task automatic chk(input string n, input logic [15:0] x, g);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, x);
        logic [7:0] d;
        logic       v;
        host_u.rd(a, d, v);
        chk(n, 16'(x), 16'(d));
        chk("rvalid", 16'h1, 16'(v));
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        print_verdict();
    end
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        fast_current_low_byte = 8'h5a;
        watchdog_enable = 1'b0;
        thermistor_cool_zone = 1'b0;
        junction_temp_c = 8'd20;
        w(4);
        rst_n = 1'b1;
        rchk("r1a", OFFSET_VOLTAGE_CFG, RESET_VOLTAGE_CFG);
        rchk("r1b", OFFSET_OFFSET_CFG, RESET_OFFSET_CFG);
        rchk("r1c", OFFSET_STROBE_LOCK, RESET_STROBE_LOCK);
        rchk("r1d", OFFSET_THERMAL_CFG, RESET_THERMAL_CFG);
        rchk("unmapped", 8'h1e, 8'h00);
        $display("test reset done");
        host_u.wr(OFFSET_VOLTAGE_CFG, 8'hff);
        rchk("locked", OFFSET_VOLTAGE_CFG, 8'h00);
        host_u.unlock();
        host_u.wr(OFFSET_VOLTAGE_CFG, 8'hff);
        rchk("cv", OFFSET_VOLTAGE_CFG, 8'hff);
        for (int k = 0; k < 16; k++) begin
            host_u.wr(OFFSET_OFFSET_CFG, {k[1:0], k[1:0], k[3:0]});
            w(3);
            chk("term", 16'(8862 + ofs[k[1:0]]), 16'(termination_mv));
            chk("trickle", 16'(125 * (k[1:0] + 1)), 16'(trickle_ma));
            chk("ocp_en", 16'(k != 0), 16'(overcurrent_enable));
            chk("ocp_ma", 16'(k ? 2500 + 500 * k : 0), 16'(overcurrent_ma));
        end
        $display("test decode done");
        host_u.wr(OFFSET_STROBE_LOCK, 8'h08);
        chk("unlocked", 16'h0, 16'(protect_unlocked));
        host_u.wr(OFFSET_OFFSET_CFG, 8'h00);
        rchk("r1b", OFFSET_OFFSET_CFG, 8'hff);
        $display("test lock done");
        host_u.unlock();
        host_u.wr(OFFSET_VOLTAGE_CFG, 8'h80);
        host_u.wr(OFFSET_STROBE_LOCK, 8'h8c);
        w(4);
        chk("active", 16'h15a, 16'(active_fast_current_code));
        chk("target", 16'h15a, 16'(fast_current_target_code));
        rchk("strobe", OFFSET_STROBE_LOCK, 8'h0c);
        // Profile still off, so the cool zone must change nothing
        thermistor_cool_zone = 1'b1;
        w(6);
        chk("target", 16'h15a, 16'(fast_current_target_code));
        chk("term", 16'd8142, 16'(termination_mv));
        host_u.wr(OFFSET_THERMAL_CFG, 8'h86);
        w(6);
        chk("target", 16'h0ad, 16'(fast_current_target_code));
        chk("term", 16'd7782, 16'(termination_mv));
        thermistor_cool_zone = 1'b0;
        w(6);
        chk("term", 16'd8142, 16'(termination_mv));
        $display("test strobe done");
        for (int k = 0; k < 16; k++) begin
            host_u.wr(OFFSET_THERMAL_CFG, {1'b0, k[3:0], 2'b00, k[0]});
            e = 85 + 5 * (k > 9 ? 9 : k);
            junction_temp_c = 8'(e + k[0]);
            w(3);
            chk("setpoint", 16'(e), 16'(thermal_setpoint_c));
            chk("flag", 16'(k[0]), 16'(thermal_regulation_flag));
            chk("foldback", 16'(k[0]), 16'(current_foldback));
            chk("ship", 16'(k[0]), 16'(factory_ship_enable));
        end
        $display("test thermal done");
        for (int i = 0; i < 8; i++) begin
            watchdog_enable = i[2];
            host_u.wr(OFFSET_STROBE_LOCK, {3'b000, i[0], 2'b11, i[1:0]});
            chk("restart", 16'(i[2] && i[1:0] == 1), 16'(watchdog_restart));
            chk("spare", 16'(i[0]), 16'(spare_bit));
        end
        $display("test watchdog done");
        print_verdict();
    end
endmodule
